// ### logic/fsl_defs.vh
/*
 Constants of the FIFO serial port: register offsets, control and status
 field positions, reset values. Assumes it is included by bare name.
*/
`ifndef FSL_DEFS_VH
`define FSL_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FSL_OFS_TX_DATA   8'h00
`define FSL_OFS_RX_DATA   8'h04
`define FSL_OFS_STATUS    8'h08
`define FSL_OFS_CTRL      8'h0c
`define FSL_OFS_BAUD      8'h10

// ----------------------------------------
// Status fields
// ----------------------------------------
`define FSL_ST_TX_ROOM    0
`define FSL_ST_RX_FILL    1
`define FSL_ST_OVERRUN    2
`define FSL_ST_TXCNT_LSB  4
`define FSL_ST_RXCNT_LSB  8

// ----------------------------------------
// Control fields
// ----------------------------------------
`define FSL_CT_TXTRG_LSB  0
`define FSL_CT_RXTRG_LSB  4
`define FSL_CT_TX_IRQ_EN  8
`define FSL_CT_RX_IRQ_EN  9
`define FSL_CT_TX_DMA_EN  10
`define FSL_CT_RX_DMA_EN  11

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FSL_RST_TXTRG     3'h1
`define FSL_RST_RXTRG     3'h1
`define FSL_RST_BAUD      16'h0056
`define FSL_RST_CTRL_EN   4'h0

`endif

// ### logic/fsl_fifo.v
/*
 Synchronous FIFO with valid/ready on both sides and a fill count.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module fsl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             core_clk_in,
  input  wire             rst_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  output wire [AW:0]      count_out
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  assign in_ready_out  = (count_reg != DEPTH[AW:0]);
  assign out_valid_out = (count_reg != {(AW+1){1'b0}});
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign count_out     = count_reg;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_ready_in & out_valid_out;

  function [AW-1:0] next_ptr;
    input [AW-1:0] p;
    begin
      next_ptr = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  always @(posedge core_clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= next_ptr(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= next_ptr(rd_ptr_reg);
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ### logic/fsl_top.v
/*
 FIFO serial port: AHB-Lite register slave, transmit and receive FIFOs,
 8N1 serial line, fill-level flags with read-1-then-write-0 clearing,
 interrupt and DMA request outputs.
 Assumes one 10 MHz clock, synchronous reset, inputs synchronous to clock.
*/
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "fsl_defs.vh"

module fsl_top #(
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire        core_clk_in,
  input  wire        rst_in,
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output reg  [31:0] hrdata_out,
  output reg         hreadyout_out,
  output reg         hresp_out,
  input  wire        serial_rx_in,
  output reg         serial_tx_out,
  output reg         tx_level_irq_out,
  output reg         rx_level_irq_out,
  output reg         tx_dma_req_out,
  output reg         rx_dma_req_out
);

  // ----------------------------------------
  // Serial state codes
  // ----------------------------------------
  localparam [3:0] S_IDLE  = 4'h1;
  localparam [3:0] S_START = 4'h2;
  localparam [3:0] S_DATA  = 4'h4;
  localparam [3:0] S_STOP  = 4'h8;

  // ----------------------------------------
  // Registers and wires
  // ----------------------------------------
  reg  [2:0]  tx_trig_reg;
  reg  [2:0]  rx_trig_reg;
  reg  [3:0]  enables_reg;
  reg  [15:0] baud_div_reg;
  reg         tx_room_flag_reg;
  reg         rx_fill_flag_reg;
  reg         overrun_reg;
  reg         tx_room_armed_reg;
  reg         rx_fill_armed_reg;
  reg         overrun_armed_reg;
  reg         wr_pend_reg;
  reg  [7:0]  wr_addr_reg;
  reg  [15:0] baud_cnt_reg;
  reg         baud_tick_reg;
  reg  [3:0]  tx_state_reg;
  reg  [2:0]  tx_bit_reg;
  reg  [7:0]  tx_shift_reg;
  reg  [3:0]  rx_state_reg;
  reg  [2:0]  rx_bit_reg;
  reg  [7:0]  rx_shift_reg;
  reg  [15:0] rx_cnt_reg;
  reg         rx_push_reg;
  reg         rx_line_reg;

  wire        addr_phase;
  wire        rd_take;
  wire        tx_stall;
  wire        wr_done;
  wire        tx_in_ready;
  wire        tx_out_valid;
  wire [7:0]  tx_out_data;
  wire [AW:0] tx_count;
  wire        tx_pop;
  wire        rx_in_ready;
  wire        rx_out_valid;
  wire [7:0]  rx_out_data;
  wire [7:0]  rx_rd_byte;
  wire [AW:0] rx_count;
  wire        rx_pop;
  wire        tx_room_cond;
  wire        rx_fill_cond;
  wire        clr_tx_room;
  wire        clr_rx_fill;
  wire        clr_overrun;
  wire [31:0] status_word;
  wire [31:0] ctrl_word;
  wire [15:0] half_div;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function [31:0] read_mux;
    input [7:0]  a;
    input [31:0] st;
    input [31:0] ct;
    input [7:0]  rxd;
    input [15:0] bd;
    begin
      case (a)
        `FSL_OFS_RX_DATA: read_mux = {24'h000000, rxd};
        `FSL_OFS_STATUS:  read_mux = st;
        `FSL_OFS_CTRL:    read_mux = ct;
        `FSL_OFS_BAUD:    read_mux = {16'h0000, bd};
        default:          read_mux = 32'h00000000;
      endcase
    end
  endfunction

  assign addr_phase = hsel_in & htrans_in[1] & hready_in;
  assign rd_take    = addr_phase & ~hwrite_in;
  // Transmit data writes hold one wait state and stall while the FIFO is full
  assign tx_stall   = wr_pend_reg & ~hreadyout_out;
  assign wr_done    = wr_pend_reg & hready_in & hreadyout_out;
  assign rx_pop     = rd_take & (haddr_in[7:0] == `FSL_OFS_RX_DATA) & (haddr_in[31:8] == 24'h000000);

  // Empty receive FIFO reads as zero, never as stale storage
  assign rx_rd_byte  = rx_out_valid ? rx_out_data : 8'h00;
  assign status_word = {21'h000000, rx_count, 1'b0, tx_count, 1'b0,
                        overrun_reg, rx_fill_flag_reg, tx_room_flag_reg};
  assign ctrl_word   = {20'h00000, enables_reg, 1'b0, rx_trig_reg, 1'b0, tx_trig_reg};

  // Clear only takes effect on a flag that was read as 1 beforehand
  assign clr_tx_room = wr_done & (wr_addr_reg == `FSL_OFS_STATUS) &
                       ~hwdata_in[`FSL_ST_TX_ROOM] & tx_room_armed_reg;
  assign clr_rx_fill = wr_done & (wr_addr_reg == `FSL_OFS_STATUS) &
                       ~hwdata_in[`FSL_ST_RX_FILL] & rx_fill_armed_reg;
  assign clr_overrun = wr_done & (wr_addr_reg == `FSL_OFS_STATUS) &
                       ~hwdata_in[`FSL_ST_OVERRUN] & overrun_armed_reg;

  // ----------------------------------------
  // FIFOs
  // ----------------------------------------
  fsl_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_tx_fifo (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (tx_stall),
    .in_ready_out  (tx_in_ready),
    .in_data_in    (hwdata_in[7:0]),
    .out_valid_out (tx_out_valid),
    .out_ready_in  (tx_pop),
    .out_data_out  (tx_out_data),
    .count_out     (tx_count)
  );

  fsl_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_rx_fifo (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (rx_push_reg),
    .in_ready_out  (rx_in_ready),
    .in_data_in    (rx_shift_reg),
    .out_valid_out (rx_out_valid),
    .out_ready_in  (rx_pop),
    .out_data_out  (rx_out_data),
    .count_out     (rx_count)
  );

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      hrdata_out    <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= 8'h00;
      tx_trig_reg   <= `FSL_RST_TXTRG;
      rx_trig_reg   <= `FSL_RST_RXTRG;
      enables_reg   <= `FSL_RST_CTRL_EN;
      baud_div_reg  <= `FSL_RST_BAUD;
    end else begin
      hresp_out <= 1'b0;
      if (tx_stall) begin
        if (tx_in_ready) begin
          hreadyout_out <= 1'b1;
          wr_pend_reg   <= 1'b0;
        end
      end else begin
        if (wr_done) begin
          wr_pend_reg <= 1'b0;
          case (wr_addr_reg)
            `FSL_OFS_CTRL: begin
              tx_trig_reg <= hwdata_in[`FSL_CT_TXTRG_LSB+2:`FSL_CT_TXTRG_LSB];
              rx_trig_reg <= hwdata_in[`FSL_CT_RXTRG_LSB+2:`FSL_CT_RXTRG_LSB];
              enables_reg <= hwdata_in[`FSL_CT_RX_DMA_EN:`FSL_CT_TX_IRQ_EN];
            end
            `FSL_OFS_BAUD: begin
              baud_div_reg <= hwdata_in[15:0];
            end
            default: begin
            end
          endcase
        end
        if (addr_phase) begin
          if (haddr_in[31:8] == 24'h000000) begin
            wr_addr_reg <= haddr_in[7:0];
          end else begin
            wr_addr_reg <= 8'hff;
          end
          if (hwrite_in) begin
            wr_pend_reg <= 1'b1;
            if (haddr_in[31:0] == {24'h000000, `FSL_OFS_TX_DATA}) begin
              hreadyout_out <= 1'b0;
            end
          end else if (haddr_in[31:8] == 24'h000000) begin
            hrdata_out <= read_mux(haddr_in[7:0], status_word, ctrl_word, rx_rd_byte, baud_div_reg);
          end else begin
            hrdata_out <= 32'h00000000;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Fill-level flags
  // ----------------------------------------
  assign tx_room_cond = (tx_count <= {1'b0, tx_trig_reg[AW-1:0]}) | (tx_trig_reg >= DEPTH[2:0]);
  assign rx_fill_cond = (rx_count >= rx_trig_reg) & (rx_trig_reg != 3'h0) &
                        ({1'b0, rx_trig_reg} <= DEPTH[3:0]);

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      tx_room_flag_reg  <= 1'b0;
      rx_fill_flag_reg  <= 1'b0;
      overrun_reg       <= 1'b0;
      tx_room_armed_reg <= 1'b0;
      rx_fill_armed_reg <= 1'b0;
      overrun_armed_reg <= 1'b0;
    end else begin
      // Set wins over a clear landing in the same cycle
      if (tx_room_cond) begin
        tx_room_flag_reg <= 1'b1;
      end else if (clr_tx_room) begin
        tx_room_flag_reg <= 1'b0;
      end
      if (rx_fill_cond) begin
        rx_fill_flag_reg <= 1'b1;
      end else if (clr_rx_fill) begin
        rx_fill_flag_reg <= 1'b0;
      end
      if (rx_push_reg & ~rx_in_ready) begin
        overrun_reg <= 1'b1;
      end else if (clr_overrun) begin
        overrun_reg <= 1'b0;
      end
      if (rd_take & (haddr_in == {24'h000000, `FSL_OFS_STATUS})) begin
        tx_room_armed_reg <= tx_room_flag_reg;
        rx_fill_armed_reg <= rx_fill_flag_reg;
        overrun_armed_reg <= overrun_reg;
      end else if (wr_done & (wr_addr_reg == `FSL_OFS_STATUS)) begin
        tx_room_armed_reg <= 1'b0;
        rx_fill_armed_reg <= 1'b0;
        overrun_armed_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupt and DMA requests
  // ----------------------------------------
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      tx_level_irq_out <= 1'b0;
      rx_level_irq_out <= 1'b0;
      tx_dma_req_out   <= 1'b0;
      rx_dma_req_out   <= 1'b0;
    end else begin
      tx_level_irq_out <= tx_room_flag_reg & enables_reg[0];
      rx_level_irq_out <= rx_fill_flag_reg & enables_reg[1];
      tx_dma_req_out   <= tx_room_flag_reg & enables_reg[2];
      rx_dma_req_out   <= rx_fill_flag_reg & enables_reg[3];
    end
  end

  // ----------------------------------------
  // Bit-rate divider
  // ----------------------------------------
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      baud_cnt_reg  <= 16'h0000;
      baud_tick_reg <= 1'b0;
    end else if (baud_cnt_reg >= baud_div_reg) begin
      baud_cnt_reg  <= 16'h0000;
      baud_tick_reg <= 1'b1;
    end else begin
      baud_cnt_reg  <= baud_cnt_reg + 16'h0001;
      baud_tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  assign tx_pop = (tx_state_reg == S_IDLE) & baud_tick_reg & tx_out_valid;

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      tx_state_reg  <= S_IDLE;
      tx_bit_reg    <= 3'h0;
      tx_shift_reg  <= 8'h00;
      serial_tx_out <= 1'b1;
    end else if (baud_tick_reg) begin
      case (tx_state_reg)
        S_IDLE: begin
          serial_tx_out <= 1'b1;
          if (tx_out_valid) begin
            tx_shift_reg  <= tx_out_data;
            serial_tx_out <= 1'b0;
            tx_state_reg  <= S_START;
          end
        end
        S_START: begin
          serial_tx_out <= tx_shift_reg[0];
          tx_shift_reg  <= {1'b0, tx_shift_reg[7:1]};
          tx_bit_reg    <= 3'h0;
          tx_state_reg  <= S_DATA;
        end
        S_DATA: begin
          if (tx_bit_reg == 3'h7) begin
            serial_tx_out <= 1'b1;
            tx_state_reg  <= S_STOP;
          end else begin
            serial_tx_out <= tx_shift_reg[0];
            tx_shift_reg  <= {1'b0, tx_shift_reg[7:1]};
            tx_bit_reg    <= tx_bit_reg + 3'h1;
          end
        end
        S_STOP: begin
          tx_state_reg <= S_IDLE;
        end
        default: begin
          tx_state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  assign half_div = {1'b0, baud_div_reg[15:1]};

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_state_reg <= S_IDLE;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_cnt_reg   <= 16'h0000;
      rx_push_reg  <= 1'b0;
      rx_line_reg  <= 1'b1;
    end else begin
      rx_line_reg <= serial_rx_in;
      rx_push_reg <= 1'b0;
      case (rx_state_reg)
        S_IDLE: begin
          rx_cnt_reg <= 16'h0000;
          if (rx_line_reg & ~serial_rx_in) begin
            rx_state_reg <= S_START;
          end
        end
        S_START: begin
          if (rx_cnt_reg >= half_div) begin
            rx_cnt_reg   <= 16'h0000;
            rx_bit_reg   <= 3'h0;
            rx_state_reg <= serial_rx_in ? S_IDLE : S_DATA;
          end else begin
            rx_cnt_reg <= rx_cnt_reg + 16'h0001;
          end
        end
        S_DATA: begin
          if (rx_cnt_reg >= baud_div_reg) begin
            rx_cnt_reg   <= 16'h0000;
            rx_shift_reg <= {serial_rx_in, rx_shift_reg[7:1]};
            if (rx_bit_reg == 3'h7) begin
              rx_state_reg <= S_STOP;
            end else begin
              rx_bit_reg <= rx_bit_reg + 3'h1;
            end
          end else begin
            rx_cnt_reg <= rx_cnt_reg + 16'h0001;
          end
        end
        S_STOP: begin
          if (rx_cnt_reg >= baud_div_reg) begin
            rx_cnt_reg   <= 16'h0000;
            rx_push_reg  <= serial_rx_in;
            rx_state_reg <= S_IDLE;
          end else begin
            rx_cnt_reg <= rx_cnt_reg + 16'h0001;
          end
        end
        default: begin
          rx_state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ### bench/fsl_top_properties.sv
/*
 Port checker of the FIFO serial port, bound into fsl_top.
 Assumes one clock, synchronous active-high reset, single AHB slave.
*/
`timescale 1ns/1ns
`include "fsl_defs.vh"
module fsl_chk (
  input wire        core_clk_in,
  input wire        rst_in,
  input wire        hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0]  htrans_in,
  input wire        hwrite_in,
  input wire        hready_in,
  input wire [31:0] hrdata_out,
  input wire        hreadyout_out,
  input wire        hresp_out,
  input wire        serial_tx_out,
  input wire        tx_level_irq_out,
  input wire        rx_level_irq_out,
  input wire        tx_dma_req_out,
  input wire        rx_dma_req_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire       rd_go = hsel_in & htrans_in[1] & hready_in & !hwrite_in;
  wire       wr_go = hsel_in & htrans_in[1] & hready_in & hwrite_in;
  wire       fl_wr = wr_go & ((haddr_in[7:0] == `FSL_OFS_STATUS) | (haddr_in[7:0] == `FSL_OFS_CTRL));
  reg  [3:0] wr_age_reg;
  // --------------------------------
  // Age of last flag or enable write
  // --------------------------------
  always @(posedge core_clk_in) begin
    if (rst_in)
      wr_age_reg <= 4'hf;
    else if (fl_wr)
      wr_age_reg <= 4'h0;
    else if (wr_age_reg != 4'hf)
      wr_age_reg <= wr_age_reg + 4'h1;
  end
  sequence s_rd;
    rd_go;
  endsequence
  sequence s_txwr;
    wr_go && (haddr_in[7:0] == `FSL_OFS_TX_DATA);
  endsequence
  a_resp_okay: assert property (!hresp_out) else $error("response not okay");
  a_reset_quiet: assert property ($fell(rst_in) |-> !tx_level_irq_out && !rx_level_irq_out && !tx_dma_req_out
    && !rx_dma_req_out && hreadyout_out && serial_tx_out && hrdata_out == 32'h0) else $error("bad reset state");
  a_read_nowait: assert property (s_rd |=> hreadyout_out) else $error("read wait state");
  a_txwr_stall: assert property (s_txwr |=> !hreadyout_out ##[0:200] hreadyout_out) else $error("tx write wait bad");
  a_rdata_stands: assert property (!$stable(hrdata_out) |-> $past(rd_go)) else $error("read data moved");
  a_txirq_clear: assert property ($fell(tx_level_irq_out) |-> wr_age_reg < 4'h6) else $error("tx irq fell");
  a_rxirq_clear: assert property ($fell(rx_level_irq_out) |-> wr_age_reg < 4'h6) else $error("rx irq fell");
  a_txdma_clear: assert property ($fell(tx_dma_req_out) |-> wr_age_reg < 4'h6) else $error("tx dma fell");
  a_rxdma_clear: assert property ($fell(rx_dma_req_out) |-> wr_age_reg < 4'h6) else $error("rx dma fell");
endmodule
bind fsl_top fsl_chk u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .serial_tx_out(serial_tx_out),
  .tx_level_irq_out(tx_level_irq_out), .rx_level_irq_out(rx_level_irq_out),
  .tx_dma_req_out(tx_dma_req_out), .rx_dma_req_out(rx_dma_req_out));

// ### bench/fsl_peer.sv
/*
 Remote serial peer, 8N1 LSB first, for the FIFO serial port.
 Assumes bit time of BIT_CLKS clocks matching the port's divider.
*/
`timescale 1ns/1ns
module fsl_peer #(
  parameter BIT_CLKS = 4
) (
  input  wire       core_clk_in,
  input  wire       rst_in,
  input  wire       line_in,
  input  wire       send_in,
  input  wire [7:0] send_byte_in,
  output reg        line_out,
  output reg        busy_out,
  output reg  [7:0] got_byte_out,
  output reg  [7:0] got_count_out
);
  reg [9:0] frame;
  reg [7:0] rb;
  integer   i;
  integer   j;
  initial begin
    line_out = 1'b1;
    busy_out = 1'b0;
    got_byte_out = 8'h00;
    got_count_out = 8'h00;
  end
  // ----------------------------
  // Send one frame per request
  // ----------------------------
  always begin
    @(posedge core_clk_in);
    if (send_in === 1'b1) begin
      frame = {1'b1, send_byte_in, 1'b0};
      busy_out <= 1'b1;
      for (i = 0; i < 10; i = i + 1) begin
        line_out <= frame[i];
        repeat (BIT_CLKS) @(posedge core_clk_in);
      end
      busy_out <= 1'b0;
    end
  end
  // ----------------------------
  // Receive at mid-bit
  // ----------------------------
  always @(negedge line_in) begin
    if (rst_in !== 1'b1) begin
      repeat (BIT_CLKS / 2) @(negedge core_clk_in);
      for (j = 0; j < 8; j = j + 1) begin
        repeat (BIT_CLKS) @(negedge core_clk_in);
        rb[j] = line_in;
      end
      repeat (BIT_CLKS) @(negedge core_clk_in);
      if (line_in === 1'b1) begin
        got_byte_out <= rb;
        got_count_out <= got_count_out + 8'h01;
      end
    end
  end
endmodule

// ### bench/fsl_top_tb.sv
/*
 Self-checking bench of the FIFO serial port: AHB-Lite master, serial peer.
 Assumes 10 MHz clock and the port's default 4-deep FIFOs.
*/
`timescale 1ns/1ns
`include "fsl_defs.vh"
module fsl_top_tb;
  reg         core_clk_in = 1'b0;
  reg         rst_in      = 1'b1;
  reg         bus_sel     = 1'b0;
  reg  [31:0] bus_addr    = 32'h0;
  reg  [1:0]  bus_trans   = 2'h0;
  reg         bus_write   = 1'b0;
  reg  [2:0]  bus_size    = 3'h2;
  reg  [31:0] bus_wdata   = 32'h0;
  reg         send        = 1'b0;
  reg  [7:0]  send_byte   = 8'h0;
  wire [31:0] hrdata_out;
  wire        hreadyout_out, hresp_out, ser_rx, ser_tx, tx_irq, rx_irq, tx_dma, rx_dma, busy;
  wire [7:0]  got_byte, got_count;
  reg  [31:0] v;
  reg  [7:0]  b [0:5];
  integer     seed = 53;
  integer     n_fail = 0;
  integer     total_checks = 0;
  integer     k;
  always #50 core_clk_in = ~core_clk_in;
  fsl_top #(.DEPTH(4), .AW(2)) dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(bus_sel),
    .haddr_in(bus_addr), .htrans_in(bus_trans), .hwrite_in(bus_write), .hsize_in(bus_size), .hwdata_in(bus_wdata),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .serial_rx_in(ser_rx), .serial_tx_out(ser_tx), .tx_level_irq_out(tx_irq), .rx_level_irq_out(rx_irq),
    .tx_dma_req_out(tx_dma), .rx_dma_req_out(rx_dma));
  fsl_peer #(.BIT_CLKS(4)) peer (.core_clk_in(core_clk_in), .rst_in(rst_in), .line_in(ser_tx), .send_in(send),
    .send_byte_in(send_byte), .line_out(ser_rx), .busy_out(busy), .got_byte_out(got_byte), .got_count_out(got_count));
  // --------------------------------
  // Checking and bus tasks
  // --------------------------------
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Request outputs lag a register write by one more edge
  task chk_out(input [3:0] exp);
    begin
      repeat (2) @(negedge core_clk_in);
      chk({tx_irq, rx_irq, tx_dma, rx_dma}, exp);
      @(posedge core_clk_in);
    end
  endtask
  // Waits for a level at negedge, so the sampling edge is never raced
  task wait_lvl(input integer sel, input [7:0] t, output [31:0] rd);
    integer n;
    begin
      n = 0;
      @(negedge core_clk_in);
      while ((sel == 0 ? hreadyout_out !== 1'b1 : sel == 1 ? busy !== 1'b0 : got_count !== t)) begin
        n = n + 1;
        if (n > 3000) begin
          n_fail = n_fail + 1;
          print_verdict;
        end
        @(negedge core_clk_in);
      end
      rd = hrdata_out;
      @(posedge core_clk_in);
    end
  endtask
  task bus(input w, input [31:0] a, input [31:0] d, output [31:0] rd);
    reg [31:0] x;
    begin
      bus_sel <= 1'b1;
      bus_trans <= 2'h2;
      bus_addr <= a;
      bus_write <= w;
      wait_lvl(0, 8'h0, x);
      bus_sel <= 1'b0;
      bus_trans <= 2'h0;
      bus_wdata <= d;
      wait_lvl(0, 8'h0, rd);
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    reg [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task rd(input [31:0] a, output [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask
  task peer_send(input [7:0] d);
    reg [31:0] x;
    begin
      send_byte <= d;
      send <= 1'b1;
      @(posedge core_clk_in);
      send <= 1'b0;
      wait_lvl(1, 8'h0, x);
    end
  endtask
  function [31:0] ctl(input [2:0] txt, input [2:0] rxt, input [3:0] en);
    ctl = (en << `FSL_CT_TX_IRQ_EN) | (rxt << `FSL_CT_RXTRG_LSB) | (txt << `FSL_CT_TXTRG_LSB);
  endfunction
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    rd(`FSL_OFS_STATUS, v);
    chk(v, 32'h1);
    rd(`FSL_OFS_CTRL, v);
    chk(v, ctl(3'h1, 3'h1, 4'h0));
    rd(`FSL_OFS_BAUD, v);
    chk(v, 32'h56);
    rd(32'h14, v);
    chk(v, 32'h0);
    chk_out(4'b0000);
    $display("test reset done");
    wr(`FSL_OFS_BAUD, 32'h3);
    wr(`FSL_OFS_CTRL, ctl(3'h1, 3'h2, 4'hf));
    chk_out(4'b1010);
    for (k = 0; k < 6; k = k + 1) begin
      v = $random(seed);
      b[k] = v[7:0];
      wr(`FSL_OFS_TX_DATA, v);
    end
    rd(`FSL_OFS_STATUS, v);
    chk(v & 32'h3, 32'h1);
    wr(`FSL_OFS_STATUS, 32'h0);
    rd(`FSL_OFS_STATUS, v);
    chk(v & 32'h3, 32'h0);
    chk_out(4'b0000);
    for (k = 0; k < 6; k = k + 1) begin
      wait_lvl(2, k + 1, v);
      chk(got_byte, b[k]);
    end
    chk_out(4'b1010);
    rd(`FSL_OFS_STATUS, v);
    wr(`FSL_OFS_STATUS, 32'h0);
    rd(`FSL_OFS_STATUS, v);
    chk(v & 32'h1, 32'h1);
    $display("test transmit done");
    for (k = 0; k < 3; k = k + 1) begin
      b[k] = $random(seed);
      peer_send(b[k]);
    end
    repeat (10) @(posedge core_clk_in);
    chk_out(4'b1111);
    rd(`FSL_OFS_STATUS, v);
    chk(v & 32'h773, 32'h303);
    wr(`FSL_OFS_STATUS, 32'h1);
    rd(`FSL_OFS_STATUS, v);
    chk(v & 32'h2, 32'h2);
    for (k = 0; k < 3; k = k + 1) begin
      rd(`FSL_OFS_RX_DATA, v);
      chk(v, b[k]);
    end
    rd(`FSL_OFS_RX_DATA, v);
    chk(v, 32'h0);
    rd(`FSL_OFS_STATUS, v);
    wr(`FSL_OFS_STATUS, 32'h1);
    rd(`FSL_OFS_STATUS, v);
    chk(v & 32'h3, 32'h1);
    chk_out(4'b1010);
    $display("test receive done");
    for (k = 0; k < 5; k = k + 1)
      peer_send($random(seed));
    repeat (10) @(posedge core_clk_in);
    rd(`FSL_OFS_STATUS, v);
    chk(v & 32'h704, 32'h404);
    $display("test overrun done");
    print_verdict;
  end
  initial begin
    #1000000;
    n_fail = n_fail + 1;
    print_verdict;
  end
endmodule
